// file: common/sfr_regs.vh
// constants for the serial frame read-reply and broadcast block
// Overview of operation
// - control high nibble is address; broadcast low nibble zero
// - reply length byte echoes count, zero reported one
// - reply words go least significant byte first
// - reply words from consecutive addresses, start onward
// - broadcast write is performed only on a good checksum, never answered
// - serial bytes shift least significant bit first
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// =============================================================
// frame bytes
`define SFR_HEAD_BYTE      8'hfe
`define SFR_CHK_OFFSET     8'h33
`define SFR_CTL_READ       4'h1
`define SFR_CTL_BCAST      4'h0
`define SFR_BCAST_LEN      4'h8
`define SFR_BCAST_LAST     4'h7
`define SFR_BITS_LAST      4'h7
// =============================================================
// bit and byte positions within a frame
`define SFR_RX_START_IDX   4'hf
`define SFR_RX_STOP_IDX    4'h8
`define SFR_TX_DONE_IDX    4'h9
`define SFR_IDX_HEAD       4'h0
`define SFR_IDX_CTL        4'h1
`define SFR_IDX_ADDR       4'h2
`define SFR_IDX_D0         4'h3
`define SFR_IDX_D1         4'h4
`define SFR_IDX_D2         4'h5
`define SFR_IDX_D3         4'h6
// =============================================================
// fifo sizing
`define SFR_FIFO_DEPTH     16
`define SFR_FIFO_AW        4
// =============================================================
// default bit period in clock cycles
`define SFR_BIT_CYCLES     16'd2170
`endif

// file: hw/sfr_fifo.v
// parameterised valid/ready fifo for reply bytes
`timescale 1ns/1ps
module sfr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk_in,
  input  wire             reset_n_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  // =============================================================
  // storage and pointers, one extra pointer bit tells full from empty
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                          (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire            empty = (wr_ptr_ff == rd_ptr_ff);
  wire            do_wr = wr_valid_in && !full;
  wire            do_rd = rd_ready_in && !empty;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rd_ptr_ff[AW-1:0]];
  // =============================================================
  // pointer update
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
  // memory write, no reset needed on data
  always @(posedge mclk_in) begin
    if (do_wr)
      mem[wr_ptr_ff[AW-1:0]] <= wr_data_in;
  end
endmodule

// file: hw/sfr_link.v
// serial link frame engine: read reply and broadcast write
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_link #(
  parameter [15:0] BIT_CYCLES = `SFR_BIT_CYCLES
) (
  input  wire        mclk_in,
  input  wire        reset_n_in,
  input  wire        rx_in,
  output reg         tx_out,
  // read request from the request decoder
  input  wire        rd_req_in,
  input  wire [11:0] rd_addr_in,
  input  wire [7:0]  rd_count_in,
  output reg         rd_busy_out,
  // register file read port
  output reg         reg_rd_out,
  output reg  [11:0] reg_rd_addr_out,
  input  wire [31:0] reg_rd_data_in,
  // register file write port for broadcast writes
  output reg         reg_wr_out,
  output reg  [11:0] reg_wr_addr_out,
  output reg  [31:0] reg_wr_data_out,
  output reg         frame_err_out
);
  // =============================================================
  // shared helpers
  function [7:0] chk_of(input [7:0] sum);
    chk_of = (~sum) + `SFR_CHK_OFFSET;
  endfunction
  // =============================================================
  // rx synchroniser and byte receiver
  reg        rx_s1_ff;
  reg        rx_s2_ff;
  reg [15:0] rx_cnt_ff;
  reg [3:0]  rx_bit_ff;
  reg [7:0]  rx_sh_ff;
  reg        rx_act_ff;
  reg        rx_stb_ff;
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_s1_ff  <= 1'b1;
      rx_s2_ff  <= 1'b1;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_sh_ff  <= 8'h00;
      rx_act_ff <= 1'b0;
      rx_stb_ff <= 1'b0;
    end else begin
      rx_s1_ff  <= rx_in;
      rx_s2_ff  <= rx_s1_ff;
      rx_stb_ff <= 1'b0;
      if (!rx_act_ff) begin
        // start bit seen: wait half a bit to centre sampling
        if (!rx_s2_ff) begin
          rx_act_ff <= 1'b1;
          rx_cnt_ff <= {1'b0, BIT_CYCLES[15:1]};
          rx_bit_ff <= `SFR_RX_START_IDX;
        end
      end else if (rx_cnt_ff != 16'h0000) begin
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      end else begin
        rx_cnt_ff <= BIT_CYCLES - 16'h0001;
        if (rx_bit_ff == `SFR_RX_START_IDX) begin
          // false start filter: line back high at centre
          if (rx_s2_ff)
            rx_act_ff <= 1'b0;
          rx_bit_ff <= 4'h0;
        end else if (rx_bit_ff == `SFR_RX_STOP_IDX) begin
          rx_act_ff <= 1'b0;
          rx_stb_ff <= 1'b1;
        end else begin
          rx_sh_ff  <= {rx_s2_ff, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
        end
      end
    end
  end
  // =============================================================
  // broadcast frame collector
  reg [3:0]  bc_idx_ff;
  reg [7:0]  bc_sum_ff;
  reg [11:0] bc_addr_ff;
  reg [31:0] bc_data_ff;
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bc_idx_ff       <= 4'h0;
      bc_sum_ff       <= 8'h00;
      bc_addr_ff      <= 12'h000;
      bc_data_ff      <= 32'h00000000;
      reg_wr_out      <= 1'b0;
      reg_wr_addr_out <= 12'h000;
      reg_wr_data_out <= 32'h00000000;
      frame_err_out   <= 1'b0;
    end else begin
      reg_wr_out    <= 1'b0;
      frame_err_out <= 1'b0;
      if (rx_stb_ff) begin
        bc_sum_ff <= bc_sum_ff + rx_sh_ff;
        bc_idx_ff <= bc_idx_ff + 4'h1;
        case (bc_idx_ff)
          `SFR_IDX_HEAD: begin
            // resync until a head byte arrives
            bc_sum_ff <= rx_sh_ff;
            if (rx_sh_ff != `SFR_HEAD_BYTE)
              bc_idx_ff <= 4'h0;
          end
          `SFR_IDX_CTL: begin
            bc_addr_ff[11:8] <= rx_sh_ff[7:4];
            // other control codes belong to other frame handlers
            if (rx_sh_ff[3:0] != `SFR_CTL_BCAST)
              bc_idx_ff <= 4'h0;
          end
          `SFR_IDX_ADDR: bc_addr_ff[7:0]   <= rx_sh_ff;
          `SFR_IDX_D0:   bc_data_ff[7:0]   <= rx_sh_ff;
          `SFR_IDX_D1:   bc_data_ff[15:8]  <= rx_sh_ff;
          `SFR_IDX_D2:   bc_data_ff[23:16] <= rx_sh_ff;
          `SFR_IDX_D3:   bc_data_ff[31:24] <= rx_sh_ff;
          `SFR_BCAST_LAST: begin
            // eighth byte closes the frame; no reply is ever queued
            bc_idx_ff <= 4'h0;
            if (rx_sh_ff == chk_of(bc_sum_ff)) begin
              reg_wr_out      <= 1'b1;
              reg_wr_addr_out <= bc_addr_ff;
              reg_wr_data_out <= bc_data_ff;
            end else begin
              frame_err_out <= 1'b1;
            end
          end
          default: bc_idx_ff <= 4'h0;
        endcase
      end
    end
  end
  // =============================================================
  // reply builder: fills the fifo with the reply frame
  localparam RB_IDLE = 3'd0;
  localparam RB_HEAD = 3'd1;
  localparam RB_CTL  = 3'd2;
  localparam RB_LEN  = 3'd3;
  localparam RB_FTCH = 3'd4;
  localparam RB_DATA = 3'd5;
  localparam RB_CHK  = 3'd6;
  localparam RB_WAIT = 3'd7;
  reg [2:0]  rb_st_ff;
  reg [11:0] rb_addr_ff;
  reg [7:0]  rb_left_ff;
  reg [7:0]  rb_len_ff;
  reg [1:0]  rb_lane_ff;
  reg [31:0] rb_word_ff;
  reg [7:0]  rb_sum_ff;
  reg [7:0]  fi_data;
  reg        fi_valid;
  wire       fi_ready;
  wire [7:0] fo_data;
  wire       fo_valid;
  wire       fo_ready;
  // byte offered to the fifo; idle, fetch and drain states offer nothing
  always @* begin
    fi_valid = (rb_st_ff != RB_IDLE) && (rb_st_ff != RB_FTCH) && (rb_st_ff != RB_WAIT);
    case (rb_st_ff)
      RB_HEAD: fi_data = `SFR_HEAD_BYTE;
      RB_CTL:  fi_data = {rb_addr_ff[11:8], `SFR_CTL_READ};
      RB_LEN:  fi_data = rb_len_ff;
      RB_DATA: fi_data = rb_word_ff[7:0];
      RB_CHK:  fi_data = chk_of(rb_sum_ff);
      default: fi_data = 8'h00;
    endcase
  end
  // sequencing; each accepted byte joins the running sum
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rb_st_ff        <= RB_IDLE;
      rb_addr_ff      <= 12'h000;
      rb_left_ff      <= 8'h00;
      rb_len_ff       <= 8'h00;
      rb_lane_ff      <= 2'b00;
      rb_word_ff      <= 32'h00000000;
      rb_sum_ff       <= 8'h00;
      rd_busy_out     <= 1'b0;
      reg_rd_out      <= 1'b0;
      reg_rd_addr_out <= 12'h000;
    end else begin
      reg_rd_out <= 1'b0;
      if (fi_valid && fi_ready)
        rb_sum_ff <= rb_sum_ff + fi_data;
      case (rb_st_ff)
        RB_IDLE: begin
          rb_sum_ff <= 8'h00;
          if (rd_req_in) begin
            // zero count means one word; 255 is the upper bound
            rb_len_ff   <= (rd_count_in == 8'h00) ? 8'h01 : rd_count_in;
            rb_left_ff  <= (rd_count_in == 8'h00) ? 8'h01 : rd_count_in;
            rb_addr_ff  <= rd_addr_in;
            rd_busy_out <= 1'b1;
            rb_st_ff    <= RB_HEAD;
          end
        end
        RB_HEAD: if (fi_ready) rb_st_ff <= RB_CTL;
        RB_CTL:  if (fi_ready) rb_st_ff <= RB_LEN;
        RB_LEN: begin
          if (fi_ready) begin
            reg_rd_out      <= 1'b1;
            reg_rd_addr_out <= rb_addr_ff;
            rb_st_ff        <= RB_FTCH;
          end
        end
        RB_FTCH: begin
          // register file answers one cycle after the strobe
          if (!reg_rd_out) begin
            rb_word_ff <= reg_rd_data_in;
            rb_lane_ff <= 2'b00;
            rb_st_ff   <= RB_DATA;
          end
        end
        RB_DATA: begin
          if (fi_ready) begin
            rb_word_ff <= {8'h00, rb_word_ff[31:8]};
            rb_lane_ff <= rb_lane_ff + 2'b01;
            if (rb_lane_ff == 2'b11) begin
              rb_left_ff <= rb_left_ff - 8'h01;
              if (rb_left_ff == 8'h01) begin
                rb_st_ff <= RB_CHK;
              end else begin
                rb_addr_ff      <= rb_addr_ff + 12'h001;
                reg_rd_out      <= 1'b1;
                reg_rd_addr_out <= rb_addr_ff + 12'h001;
                rb_st_ff        <= RB_FTCH;
              end
            end
          end
        end
        RB_CHK: if (fi_ready) rb_st_ff <= RB_WAIT;
        RB_WAIT: begin
          // hold busy until the fifo is drained and the transmitter is idle
          if (!fo_valid && fo_ready) begin
            rd_busy_out <= 1'b0;
            rb_st_ff    <= RB_IDLE;
          end
        end
        default: rb_st_ff <= RB_IDLE;
      endcase
    end
  end
  // =============================================================
  // reply byte buffer; the transmitter stalls the builder through it
  sfr_fifo #(
    .WIDTH (8),
    .DEPTH (`SFR_FIFO_DEPTH),
    .AW    (`SFR_FIFO_AW)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .reset_n_in   (reset_n_in),
    .wr_data_in   (fi_data),
    .wr_valid_in  (fi_valid),
    .wr_ready_out (fi_ready),
    .rd_data_out  (fo_data),
    .rd_valid_out (fo_valid),
    .rd_ready_in  (fo_ready)
  );
  // =============================================================
  // byte transmitter: start, eight data lsb first, stop
  reg [15:0] tx_cnt_ff;
  reg [3:0]  tx_bit_ff;
  reg [8:0]  tx_sh_ff;
  reg        tx_act_ff;
  assign fo_ready = !tx_act_ff;
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_out    <= 1'b1;
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff  <= 9'h1ff;
      tx_act_ff <= 1'b0;
    end else if (!tx_act_ff) begin
      tx_out <= 1'b1;
      if (fo_valid) begin
        tx_act_ff <= 1'b1;
        tx_out    <= 1'b0;
        tx_sh_ff  <= {1'b1, fo_data};
        tx_cnt_ff <= BIT_CYCLES - 16'h0001;
        tx_bit_ff <= 4'h0;
      end
    end else if (tx_cnt_ff != 16'h0000) begin
      tx_cnt_ff <= tx_cnt_ff - 16'h0001;
    end else begin
      tx_cnt_ff <= BIT_CYCLES - 16'h0001;
      if (tx_bit_ff == `SFR_TX_DONE_IDX) begin
        tx_act_ff <= 1'b0;
      end else begin
        tx_out    <= tx_sh_ff[0];
        tx_sh_ff  <= {1'b1, tx_sh_ff[8:1]};
        tx_bit_ff <= tx_bit_ff + 4'h1;
      end
    end
  end
endmodule

// file: sim/sfr_host.sv
// host model: broadcast frame sender and reply byte receiver
`timescale 1ns/1ps
module sfr_host #(
  parameter BITC = 8
) (
  input  wire       mclk_in,
  input  wire       tx_in,
  output reg        rx_out,
  output reg  [7:0] byte_out,
  output reg        byte_vld_out
);
  integer   i;
  integer   j;
  integer   k;
  reg [7:0] sh;  // receive shifter
  reg [7:0] sum; // running sum of sent bytes
  initial begin
    rx_out = 1'b1;
    byte_out = 8'h00;
    byte_vld_out = 1'b0;
  end
  // one byte, lsb first, then gap idle bit times (a slow host)
  task send(input [7:0] b, input integer gap);
    begin
      sum = sum + b;
      for (i = 0; i < 10 + gap; i = i + 1) begin
        rx_out <= (i == 0) ? 1'b0 : (i < 9) ? b[i-1] : 1'b1;
        repeat (BITC) @(posedge mclk_in);
      end
    end
  endtask
  // broadcast write; lo and bad let a scenario spoil the frame
  task bcast(input [11:0] a, input [31:0] d, input [3:0] lo, input [7:0] bad);
    begin
      sum = 8'h00;
      send(8'hfe, 0);
      send({a[11:8], lo}, 0);
      send(a[7:0], 0);
      for (j = 0; j < 4; j = j + 1) send(d[8*j +: 8], j);
      send((~sum + 8'h33) ^ bad, 2);
    end
  endtask
  // sample each reply bit at its centre
  always begin
    @(negedge tx_in);
    repeat (BITC / 2) @(posedge mclk_in);
    for (k = 0; k < 8; k = k + 1) begin
      repeat (BITC) @(posedge mclk_in);
      sh[k] = tx_in;
    end
    repeat (BITC) @(posedge mclk_in);
    byte_out <= sh;
    byte_vld_out <= 1'b1;
    @(posedge mclk_in);
    byte_vld_out <= 1'b0;
  end
endmodule

// file: sim/sfr_link_asserts.sv
// port checker for the serial frame engine
`timescale 1ns/1ps
module sfr_link_asserts #(
  parameter [15:0] BIT_CYCLES = 16'd8
) (
  input wire        mclk_in,
  input wire        reset_n_in,
  input wire        tx_out,
  input wire        rd_req_in,
  input wire [11:0] rd_addr_in,
  input wire        rd_busy_out,
  input wire        reg_rd_out,
  input wire [11:0] reg_rd_addr_out,
  input wire        reg_wr_out,
  input wire        frame_err_out
);
  // =====================
  // expected word address
  reg [11:0] exp_a_ff; // next address the reply must read
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) exp_a_ff <= 12'h000;
    else if (rd_req_in && !rd_busy_out) exp_a_ff <= rd_addr_in;
    else if (reg_rd_out) exp_a_ff <= exp_a_ff + 12'h001;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // =====================
  // properties
  req_take_a: assert property (rd_req_in && !rd_busy_out |=> rd_busy_out)
    else $error("request not taken");
  idle_high_a: assert property (!rd_busy_out |-> tx_out)
    else $error("line active while idle");
  start_soon_a: assert property ($rose(rd_busy_out) |-> ##[1:12] !tx_out)
    else $error("reply start bit late");
  word_addr_a: assert property (reg_rd_out |-> reg_rd_addr_out == exp_a_ff)
    else $error("reply word address wrong");
  rd_in_reply_a: assert property (reg_rd_out |-> rd_busy_out)
    else $error("register read outside reply");
  wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write strobe too long");
  err_no_wr_a: assert property (frame_err_out |-> !reg_wr_out ##1 !reg_wr_out)
    else $error("write on bad frame");
  busy_cause_a: assert property ($rose(rd_busy_out) |-> $past(rd_req_in))
    else $error("reply without request");
  bit_len_a: assert property (BIT_CYCLES == 16'd8 && $fell(tx_out) |-> !tx_out [*8])
    else $error("low bit too short");
  cover property (reg_wr_out);
  cover property (frame_err_out);
  cover property ($fell(rd_busy_out));
endmodule
bind sfr_link sfr_link_asserts #(.BIT_CYCLES(BIT_CYCLES)) sfr_link_asserts_inst (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .tx_out(tx_out),
  .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_busy_out(rd_busy_out),
  .reg_rd_out(reg_rd_out), .reg_rd_addr_out(reg_rd_addr_out),
  .reg_wr_out(reg_wr_out), .frame_err_out(frame_err_out));

// file: sim/tb.sv
// self-checking bench for the serial frame engine
`timescale 1ns/1ps
module tb;
  reg         mclk_in = 1'b0;
  reg         reset_n_in = 1'b0;
  reg         rd_req_in = 1'b0;
  reg  [11:0] rd_addr_in = 12'h000;
  reg  [7:0]  rd_count_in = 8'h00;
  reg  [31:0] reg_rd_data_in = 32'h0;
  wire        rx_in;
  wire        tx_out;
  wire        rd_busy_out;
  wire        reg_rd_out;
  wire        reg_wr_out;
  wire        frame_err_out;
  wire [11:0] reg_rd_addr_out;
  wire [11:0] reg_wr_addr_out;
  wire [31:0] reg_wr_data_out;
  wire [7:0]  hb;
  wire        hv;
  // output levels packed for the reset check
  wire [7:0]  outs_now = {3'b000, tx_out, rd_busy_out, reg_rd_out, reg_wr_out, frame_err_out};
  integer     n_fail = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  integer     n_err = 0;
  integer     t;
  reg  [31:0] seed = 32'hd861;
  reg  [7:0]  ssum;   // sum of expected reply bytes
  reg  [7:0]  bq[$];  // expected reply bytes
  reg  [43:0] wq[$];  // expected writes
  always #2 mclk_in = ~mclk_in;
  sfr_link #(.BIT_CYCLES(16'd8)) sfr_link_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .rx_in(rx_in), .tx_out(tx_out), .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in),
    .rd_count_in(rd_count_in), .rd_busy_out(rd_busy_out), .reg_rd_out(reg_rd_out),
    .reg_rd_addr_out(reg_rd_addr_out), .reg_rd_data_in(reg_rd_data_in),
    .reg_wr_out(reg_wr_out), .reg_wr_addr_out(reg_wr_addr_out),
    .reg_wr_data_out(reg_wr_data_out), .frame_err_out(frame_err_out));
  sfr_host #(.BITC(8)) sfr_host_inst (.mclk_in(mclk_in), .tx_in(tx_out), .rx_out(rx_in),
    .byte_out(hb), .byte_vld_out(hv));
  function [31:0] rnd(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      rnd = y ^ (y << 5);
    end
  endfunction
  // register content follows the address so words are told apart
  function [31:0] regval(input [11:0] a);
    regval = {a[7:0], 4'h5, a, ~a[7:0]};
  endfunction
  always @(posedge mclk_in) if (reg_rd_out) reg_rd_data_in <= regval(reg_rd_addr_out);
  // =====================
  // compares and closing
  task chk_byte(input string nm, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk_wr(input [43:0] e, input [43:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] write exp %h got %h", e, g);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // =====================
  // observers: oldest note against each result
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (frame_err_out === 1'b1) n_err = n_err + 1;
    if (hv === 1'b1) chk_byte("reply byte", bq.pop_front(), hb);
    if (reg_wr_out === 1'b1) chk_wr(wq.pop_front(), {reg_wr_addr_out, reg_wr_data_out});
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      $display("[ERR] run exp finish got hang");
      final_report;
    end
  end
  task put(input [7:0] x);
    begin
      bq.push_back(x);
      ssum = ssum + x;
    end
  endtask
  // read reply; poke retries the request while busy, which is ignored
  task rd(input [11:0] a, input [7:0] c, input poke);
    integer w;
    integer b;
    reg [31:0] v;
    begin
      ssum = 8'h00;
      put(8'hfe);
      put({a[11:8], 4'h1});
      put((c == 8'h00) ? 8'h01 : c);
      for (w = 0; w < ((c == 8'h00) ? 1 : c); w = w + 1) begin
        v = regval(a + w[11:0]);
        for (b = 0; b < 4; b = b + 1) put(v[8*b +: 8]);
      end
      bq.push_back(~ssum + 8'h33);
      rd_addr_in <= a;
      rd_count_in <= c;
      rd_req_in <= 1'b1;
      @(posedge mclk_in);
      rd_req_in <= 1'b0;
      repeat (40) @(posedge mclk_in);
      rd_req_in <= poke;
      rd_addr_in <= 12'h777;
      @(posedge mclk_in);
      rd_req_in <= 1'b0;
      for (w = 0; w < 20000 && rd_busy_out !== 1'b0; w = w + 1) @(posedge mclk_in);
    end
  endtask
  task bc(input [11:0] a, input [31:0] d, input [3:0] lo, input [7:0] bad);
    begin
      if (lo == 4'h0 && bad == 8'h00) wq.push_back({a, d});
      sfr_host_inst.bcast(a, d, lo, bad);
      repeat (20) @(posedge mclk_in);
    end
  endtask
  // =====================
  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(12'h1ff, 8'h02, 1'b1);
    rd(12'h040, 8'h00, 1'b0);
    for (t = 0; t < 3; t = t + 1) begin
      seed = rnd(seed);
      rd({seed[11:4], 4'h0}, {5'h00, seed[14:12]}, 1'b0);
    end
    // mid-run reset while idle: line held high, strobes low
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk_byte("outputs in reset", 8'h10, outs_now);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(12'hffe, 8'h03, 1'b0);
    $display("reads done");
    for (t = 0; t < 3; t = t + 1) begin
      seed = rnd(seed);
      bc(seed[11:0], rnd(seed), 4'h0, 8'h00);
    end
    bc(12'h5a3, 32'h01234567, 4'h3, 8'h00);
    bc(12'h5a3, 32'h89abcdef, 4'h0, 8'h01);
    bc(12'hfff, 32'hffffffff, 4'h0, 8'h00);
    chk_byte("frame errors", 8'h01, n_err[7:0]);
    chk_byte("bytes left", 8'h00, 8'(bq.size()));
    chk_byte("writes left", 8'h00, 8'(wq.size()));
    $display("broadcasts done");
    final_report;
  end
endmodule
